// >>> src/decode_defines.svh
`ifndef DECODE_DEFINES_SVH
`define DECODE_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_INSTR    12'h000
`define REG_STATUS   12'h004
`define REG_WORK     12'h008
`define REG_BANK     12'h00C
`define REG_MEM_ADDR 12'h010
`define REG_MEM_DATA 12'h014
`define REG_PTR0     12'h018
`define REG_PTR1     12'h01C
`define REG_PTR2     12'h020

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define ST_BUSY    0
`define ST_ZERO    1
`define ST_NEG     2
`define ST_ILLEGAL 3
`define ST_REFUSED 4

// ----------------------------------------
// Opcode prefixes
// ----------------------------------------
`define OP_OR     6'h04
`define OP_COPY   6'h14
`define OP_PTR    8'hEE
`define OP_PTR2   8'hF0
`define OP_F2F    4'hC
`define OP_SECOND 4'hF
`define OP_BANK   8'h01
`define OP_WORK   8'h0E

// ----------------------------------------
// Address map, reset values and phase timing
// ----------------------------------------
`define ACCESS_SPLIT 8'h80
`define ACCESS_HIGH  4'hF
`define WORK_ADDR    12'hFE8
`define RESET_BYTE   8'h00
`define Q_LAST       2'h3
`define Q_DIV_DEFAULT 1

`endif

// >>> src/decode_pkg.sv
package decode_pkg;

  // Decoded instruction kinds
  typedef enum logic [2:0] {
    op_illegal,
    op_or_working_with_file,
    op_copy_file_register,
    op_load_pointer_literal,
    op_copy_file_to_file,
    op_load_bank_literal,
    op_load_working_literal
  } op_e;

  // Instruction cycle sequencer
  typedef enum logic [1:0] {
    st_idle,
    st_first,
    st_second
  } exec_e;

  // Instruction pair as written by software
  typedef struct packed {
    logic [15:0] second;
    logic [15:0] first;
  } instr_s;

  // Arithmetic flags
  typedef struct packed {
    logic neg;
    logic zero;
  } flags_s;

endpackage

// >>> src/or_and_move_instruction_decode.sv
`timescale 1ns/1ns
`include "decode_defines.svh"

module or_and_move_instruction_decode #(
  parameter int Q_DIV = `Q_DIV_DEFAULT,
  parameter int DEPTH = 4096
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state
  output logic busy,
  output decode_pkg::flags_s flags
);
  import decode_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  exec_e state;
  logic [1:0] phase;
  logic [15:0] div_cnt;
  instr_s instr;
  logic [7:0] working_register;
  logic [7:0] bank;
  logic [3:0] ptr_hi [0:2];
  logic [7:0] ptr_lo [0:2];
  logic [7:0] mem [0:DEPTH-1];
  logic [7:0] held;
  logic [7:0] result;
  logic illegal;
  logic refused;
  logic [11:0] mem_addr;

  // ----------------------------------------
  // Phase divider
  // ----------------------------------------
  localparam logic [15:0] DIV_LAST = 16'(Q_DIV - 1);
  wire logic q_en = (div_cnt == DIV_LAST);

  // Divider counts only while executing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
    end else if (state == st_idle || q_en) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire logic is_or = (instr.first[15:10] == `OP_OR);
  wire logic is_copy = (instr.first[15:10] == `OP_COPY);
  wire logic is_ptr = (instr.first[15:8] == `OP_PTR)
    && (instr.first[5:4] != 2'h3);
  wire logic is_f2f = (instr.first[15:12] == `OP_F2F);
  wire logic is_bank = (instr.first[15:8] == `OP_BANK);
  wire logic is_work = (instr.first[15:8] == `OP_WORK);
  wire op_e op = is_or ? op_or_working_with_file :
                 is_copy ? op_copy_file_register :
                 is_ptr ? op_load_pointer_literal :
                 is_f2f ? op_copy_file_to_file :
                 is_bank ? op_load_bank_literal :
                 is_work ? op_load_working_literal : op_illegal;
  wire logic two_word = (op == op_load_pointer_literal)
    || (op == op_copy_file_to_file);
  wire logic second_ok = (op == op_load_pointer_literal) ?
    (instr.second[15:8] == `OP_PTR2) :
    (instr.second[15:12] == `OP_SECOND);

  // Operand fields
  wire logic [7:0] file_f = instr.first[7:0];
  wire logic sel_d = instr.first[9];
  wire logic sel_a = instr.first[8];
  wire logic [1:0] ptr_sel = instr.first[5:4];
  wire logic [7:0] literal = instr.first[7:0];

  // ----------------------------------------
  // Address formation
  // ----------------------------------------
  // Access bank splits low RAM and high special registers
  wire logic [11:0] access_addr = (file_f >= `ACCESS_SPLIT) ?
    {`ACCESS_HIGH, file_f} : {4'h0, file_f};
  wire logic [11:0] bank_addr = sel_a ?
    {bank[3:0], file_f} : access_addr;
  wire logic [11:0] src_addr = (op == op_copy_file_to_file) ?
    instr.first[11:0] : bank_addr;
  wire logic [11:0] dst_addr = (op == op_copy_file_to_file) ?
    instr.second[11:0] : bank_addr;

  // Read port, working register mapped into data space
  wire logic [7:0] file_rd = (src_addr == `WORK_ADDR) ?
    working_register : mem[src_addr];

  // ----------------------------------------
  // Process data
  // ----------------------------------------
  wire logic [7:0] alu = (op == op_or_working_with_file) ?
    (working_register | held) : held;

  // Phase strobes
  wire logic in_first = (state == st_first);
  wire logic in_second = (state == st_second);
  wire logic q1 = q_en && (phase == 2'h0);
  wire logic q2 = q_en && (phase == 2'h1);
  wire logic q3 = q_en && (phase == 2'h2);
  wire logic q4 = q_en && (phase == `Q_LAST);
  wire logic bad_first = in_first && q1 && (op == op_illegal);
  wire logic bad_second = in_second && q1 && !second_ok;

  // ----------------------------------------
  // Write port selection
  // ----------------------------------------
  wire logic alu_op = (op == op_or_working_with_file)
    || (op == op_copy_file_register);
  wire logic alu_wr = in_first && q4 && alu_op;
  wire logic alu_to_file = alu_wr && sel_d;
  wire logic f2f_wr = in_second && q4
    && (op == op_copy_file_to_file);
  wire logic core_wr = alu_to_file || f2f_wr;
  wire logic [7:0] core_data = f2f_wr ? held : result;
  wire logic core_to_work = core_wr && (dst_addr == `WORK_ADDR);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic access = psel && penable;
  wire logic setup = psel && !penable;
  wire logic hit_instr = (paddr == `REG_INSTR);
  wire logic hit_status = (paddr == `REG_STATUS);
  wire logic hit_work = (paddr == `REG_WORK);
  wire logic hit_bank = (paddr == `REG_BANK);
  wire logic hit_maddr = (paddr == `REG_MEM_ADDR);
  wire logic hit_mdata = (paddr == `REG_MEM_DATA);
  wire logic hit_ptr0 = (paddr == `REG_PTR0);
  wire logic hit_ptr1 = (paddr == `REG_PTR1);
  wire logic hit_ptr2 = (paddr == `REG_PTR2);
  wire logic hit_any = hit_instr || hit_status || hit_work || hit_bank
    || hit_maddr || hit_mdata || hit_ptr0 || hit_ptr1 || hit_ptr2;
  wire logic wr_acc = access && pwrite && hit_any;
  wire logic start = wr_acc && hit_instr && (state == st_idle);
  wire logic sw_mem_wr = wr_acc && hit_mdata && (state == st_idle);
  wire logic refuse_now = wr_acc && (state != st_idle)
    && (hit_instr || hit_mdata);

  // Zero-wait slave, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign busy = (state != st_idle);

  // Status word as software sees it
  wire logic [31:0] status_word = {27'h0000000, refused, illegal,
    flags.neg, flags.zero, busy};

  // Read mux, captured in the setup cycle
  wire logic [31:0] rd_mux =
    hit_instr ? instr :
    hit_status ? status_word :
    hit_work ? {24'h000000, working_register} :
    hit_bank ? {24'h000000, bank} :
    hit_maddr ? {20'h00000, mem_addr} :
    hit_mdata ? {24'h000000, mem[mem_addr]} :
    hit_ptr0 ? {20'h00000, ptr_hi[0], ptr_lo[0]} :
    hit_ptr1 ? {20'h00000, ptr_hi[1], ptr_lo[1]} :
    hit_ptr2 ? {20'h00000, ptr_hi[2], ptr_lo[2]} : 32'h00000000;

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Four phases per cycle, one or two cycles per instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      phase <= 2'h0;
    end else if (start) begin
      state <= st_first;
      phase <= 2'h0;
    end else if (bad_first || bad_second) begin
      state <= st_idle;
      phase <= 2'h0;
    end else if (q_en && state != st_idle) begin
      phase <= phase + 2'h1;
      if (q4 && in_first && two_word) begin
        state <= st_second;
      end else if (q4) begin
        state <= st_idle;
      end
    end
  end

  // Instruction words from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= 32'h00000000;
    end else if (start) begin
      instr <= pwdata;
    end
  end

  // Operand capture in read phase, result in process phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= `RESET_BYTE;
      result <= `RESET_BYTE;
    end else if (in_first && q2) begin
      held <= file_rd;
    end else if (in_first && q3) begin
      result <= alu;
    end
  end

  // ----------------------------------------
  // Core registers
  // ----------------------------------------
  // Working register: literal, ALU result or mapped write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_register <= `RESET_BYTE;
    end else if (in_first && q4 && op == op_load_working_literal) begin
      working_register <= literal;
    end else if (alu_wr && !sel_d) begin
      working_register <= result;
    end else if (core_to_work) begin
      working_register <= core_data;
    end
  end

  // Bank select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank <= `RESET_BYTE;
    end else if (in_first && q4 && op == op_load_bank_literal) begin
      bank <= literal;
    end
  end

  // Pointer registers, high nibble then low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        ptr_hi[i] <= 4'h0;
        ptr_lo[i] <= 8'h00;
      end
    end else if (op == op_load_pointer_literal && q4) begin
      if (in_first) begin
        ptr_hi[ptr_sel] <= instr.first[3:0];
      end else if (in_second) begin
        ptr_lo[ptr_sel] <= instr.second[7:0];
      end
    end
  end

  // Negative and zero only from OR and copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 2'b00;
    end else if (alu_wr) begin
      flags.neg <= result[7];
      flags.zero <= (result == 8'h00);
    end
  end

  // Sticky error flags, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal <= 1'b0;
      refused <= 1'b0;
    end else begin
      if (bad_first || bad_second) begin
        illegal <= 1'b1;
      end else if (wr_acc && hit_status && pwdata[`ST_ILLEGAL]) begin
        illegal <= 1'b0;
      end
      if (refuse_now) begin
        refused <= 1'b1;
      end else if (wr_acc && hit_status && pwdata[`ST_REFUSED]) begin
        refused <= 1'b0;
      end
    end
  end

  // Software memory pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= 12'h000;
    end else if (wr_acc && hit_maddr) begin
      mem_addr <= pwdata[11:0];
    end
  end

  // ----------------------------------------
  // Data memory
  // ----------------------------------------
  wire logic mem_we = (core_wr && !core_to_work) || sw_mem_wr;
  wire logic [11:0] mem_wa = core_wr ? dst_addr : mem_addr;
  wire logic [7:0] mem_wd = core_wr ? core_data : pwdata[7:0];

  // Single write port, no reset on the array
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

endmodule

// >>> bench/decode_chk.sv
`timescale 1ns/1ns
module decode_chk
  import decode_pkg::*;
#(
  parameter int Q_DIV = 1,
  parameter int DEPTH = 4096
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core state
  input wire logic busy,
  input wire decode_pkg::flags_s flags
);
  // ----------------------------------------
  // Decode of the accepted instruction write
  // ----------------------------------------
  wire logic acc = psel && penable;
  wire logic start = acc && pwrite && paddr == 12'h000 && !busy;
  wire logic [15:0] w1 = pwdata[15:0];
  wire logic [15:0] w2 = pwdata[31:16];
  wire logic one_op = w1[15:10] == 6'h04 || w1[15:10] == 6'h14;
  wire logic lit_op = w1[15:8] == 8'h01 || w1[15:8] == 8'h0E;
  wire logic ptr_op = w1[15:8] == 8'hEE && w1[5:4] != 2'h3 &&
    w2[15:8] == 8'hF0;
  wire logic f2f_op = w1[15:12] == 4'hC && w2[15:12] == 4'hF;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Bus and sequencing checks
  // ----------------------------------------
  err_in_access_a: assert property (pslverr |-> acc)
    else $error("error response outside access phase");
  unmapped_err_a: assert property (acc && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    acc && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  exec_start_a: assert property (start |=> busy)
    else $error("execution did not start");
  one_word_a: assert property (
    start && (one_op || lit_op) |=> busy [*4] ##1 !busy)
    else $error("one-word op not four cycles");
  ptr_len_a: assert property (
    start && ptr_op |=> busy [*8] ##1 !busy)
    else $error("pointer load not eight cycles");
  f2f_len_a: assert property (
    start && f2f_op |=> busy [*8] ##1 !busy)
    else $error("file move not eight cycles");
  lit_flags_a: assert property (
    start && lit_op |=> $stable(flags) [*5])
    else $error("literal load changed flags");
  two_flags_a: assert property (
    start && (ptr_op || f2f_op) |=> $stable(flags) [*8])
    else $error("two-word op changed flags");
  idle_flags_a: assert property (!$past(busy) |-> $stable(flags))
    else $error("flags moved while idle");

  // Main scenarios reached
  cover property (start && one_op);
  cover property (start && ptr_op);
  cover property (start && f2f_op);
  cover property (pslverr);
endmodule

// >>> bench/or_and_move_instruction_decode_tb.sv
`timescale 1ns/1ns
module or_and_move_instruction_decode_tb;
  import decode_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  flags_s flags;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int num_checks = 0;

  // Clock at 100 MHz
  always #5 pclk = ~pclk;

  or_and_move_instruction_decode DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .flags(flags));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // One APB transfer, result left in rdat and rerr
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  // Wait for the core to finish, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge pclk);
    while (busy !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask

  task automatic exec(input logic [31:0] i);
    wr(12'h000, i);
    wait_idle();
  endtask

  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    wr(12'h010, {20'h0, a});
    wr(12'h014, {24'h0, d});
  endtask

  task automatic mr(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    wr(12'h010, {20'h0, a});
    rd(nm, 12'h014, e);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd("status", 12'h004, 32'h0);
    rd("work", 12'h008, 32'h0);
    rd("ptr2", 12'h020, 32'h0);
    // Literal loads
    exec(32'h0000_0E91);
    rd("work", 12'h008, 32'h91);
    exec(32'h0000_0105);
    rd("bank", 12'h00C, 32'h05);
    // OR into working register through bank 5
    mw(12'h513, 8'h13);
    exec(32'h0000_1113);
    rd("work", 12'h008, 32'h93);
    mr("file", 12'h513, 32'h13);
    rd("status", 12'h004, 32'h04);
    // OR back to file, top of upper access bank
    exec(32'h0000_0E0E);
    mw(12'hFFF, 8'h30);
    exec(32'h0000_12FF);
    mr("file", 12'hFFF, 32'h3E);
    rd("work", 12'h008, 32'h0E);
    rd("status", 12'h004, 32'h0);
    // Copy a zero byte from lower access bank
    mw(12'h020, 8'h00);
    exec(32'h0000_5020);
    rd("work", 12'h008, 32'h0);
    chk("flags", 32'h1, {30'h0, flags});
    // Pointer loads, good and broken
    exec(32'hF0AB_EE23);
    rd("ptr2", 12'h020, 32'h3AB);
    rd("status", 12'h004, 32'h02);
    exec(32'h1234_EE15);
    rd("ptr1", 12'h01C, 32'h500);
    rd("status", 12'h004, 32'h0A);
    wr(12'h004, 32'h08);
    exec(32'hF000_EE30);
    rd("status", 12'h004, 32'h0A);
    wr(12'h004, 32'h08);
    // File moves into and out of the working register, then file to file
    exec(32'h0000_0E5A);
    exec(32'hF100_CFE8);
    mr("file", 12'h100, 32'h5A);
    exec(32'hFFE8_CFFF);
    rd("work", 12'h008, 32'h3E);
    exec(32'hF000_C100);
    mr("file", 12'h000, 32'h5A);
    rd("status", 12'h004, 32'h02);
    // Instruction written while busy is dropped
    wr(12'h000, 32'h0000_0E77);
    wr(12'h000, 32'h0000_0E11);
    wait_idle();
    rd("work", 12'h008, 32'h77);
    rd("status", 12'h004, 32'h12);
    // Memory write while busy is dropped
    wr(12'h004, 32'h10);
    wr(12'h000, 32'h0000_0E01);
    wr(12'h014, 32'h0000_0055);
    wait_idle();
    rd("status", 12'h004, 32'h12);
    rd("mdata", 12'h014, 32'h5A);
    // Bad second word of a file move
    exec(32'h0100_C100);
    rd("status", 12'h004, 32'h1A);
    wr(12'h004, 32'h18);
    rd("status", 12'h004, 32'h02);
    // Copy back to file through bank 5, then pointer 0
    exec(32'h0000_5313);
    mr("file", 12'h513, 32'h13);
    rd("work", 12'h008, 32'h01);
    chk("flags", 32'h0, {30'h0, flags});
    exec(32'hF0FF_EE0F);
    rd("ptr0", 12'h018, 32'hFFF);
    // Reset in the middle of an instruction
    wr(12'h000, 32'h0000_0E33);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("prdata", 32'h0, prdata);
    rd("status", 12'h004, 32'h0);
    rd("work", 12'h008, 32'h0);
    rd("bank", 12'h00C, 32'h0);
    rd("ptr0", 12'h018, 32'h0);
    // Unmapped read
    apb(1'b0, 12'h040, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("unmapped", 32'h0, rdat);
    report_and_stop();
  end
endmodule

bind or_and_move_instruction_decode decode_chk #(
  .Q_DIV(Q_DIV), .DEPTH(DEPTH)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy), .flags(flags));
